// >>> design/resource_config_decoder.sv
// Resource configuration decoder with an AXI4-Lite register slave.
`timescale 1ns/1ps
module resource_config_decoder (
	input wire logic REF_CLK,
	input wire logic ARST_N,
	input wire logic [7:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [7:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	input wire logic [31:0] TIMER_NOW,
	input wire logic [31:0] PORT_SAMPLE,
	input wire logic [rcd_pkg::NUM_CLKBLKS-1:0] CB_SRC,
	input wire logic [rcd_pkg::NUM_SDM-1:0] SDM_MISS,
	output logic PORT_FLUSH,
	output logic [5:0] PORT_FLUSH_IDX,
	output logic COND_PASS,
	output logic [rcd_pkg::NUM_TIMERS-1:0] TIMER_READY,
	output logic [rcd_pkg::NUM_CLKBLKS-1:0] CB_OUT,
	output logic [rcd_pkg::NUM_CLKBLKS-1:0] CB_RUNNING,
	output logic [rcd_pkg::NUM_SDM-1:0] SDM_ROUTE,
	output logic [rcd_pkg::NUM_SDM-1:0] SDM_EVENT,
	output logic [rcd_pkg::NUM_SDM-1:0] SDM_IRQ
);
	import rcd_pkg::*;

	// Merges a bus write into an old word under the byte strobes.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	// Write channel holding registers; address and data may come in either order.
	logic aw_full_q;
	logic [7:0] aw_addr_q;
	logic w_full_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	// Software visible registers.
	logic [31:0] select_q;
	logic [31:0] operand_q;
	logic accepted_q;
	logic refused_q;

	// Resource configuration state.
	logic [PF_W-1:0] port_cfg_q [NUM_PORTS];
	logic [31:0] port_test_q [NUM_PORTS];
	logic [NUM_TIMERS-1:0] tmr_after_q;
	logic [NUM_TIMERS-1:0] tmr_irq_q;
	logic [31:0] tmr_cmp_q [NUM_TIMERS];
	logic [NUM_CHANENDS-1:0] chan_irq_q;
	logic [CF_W-1:0] cb_cfg_q [NUM_CLKBLKS];
	logic [NUM_SDM-1:0] sdm_en_q;
	logic [NUM_SDM-1:0] sdm_irq_q;
	logic [NUM_SDM-1:0] sdm_pend_q;

	// Clock block edge engines.
	logic [NUM_CLKBLKS-1:0] src_q;
	logic [NUM_CLKBLKS-1:0] pend_q;
	logic [NUM_CLKBLKS-1:0] pend_lvl_q;
	logic [8:0] cnt_q [NUM_CLKBLKS];

	// Bus handshakes are combinational from the holding flags.
	assign AWREADY = !aw_full_q;
	assign WREADY = !w_full_q;
	assign ARREADY = !rvalid_q;
	assign BVALID = bvalid_q;
	assign BRESP = bresp_q;
	assign RVALID = rvalid_q;
	assign RDATA = rdata_q;
	assign RRESP = rresp_q;

	// A write is performed once both halves are held and no response waits.
	wire wr_fire = aw_full_q && w_full_q && !bvalid_q;
	wire [31:0] wr_word = merge(32'h0000_0000, w_data_q, w_strb_q);
	wire wr_known = (aw_addr_q == OFF_SELECT) || (aw_addr_q == OFF_CONFIG) ||
		(aw_addr_q == OFF_TEST) || (aw_addr_q == OFF_STATUS) || (aw_addr_q == OFF_VIEW);
	wire issue = wr_fire && (aw_addr_q == OFF_CONFIG);
	wire test_wr = wr_fire && (aw_addr_q == OFF_TEST);

	// Selected resource.
	wire [2:0] sel_kind = select_q[SEL_KIND_LSB +: 3];
	wire [5:0] sel_idx = select_q[SEL_IDX_LSB +: 6];

	// Operand decode: reserved bits 31..16 are ignored except for pad options.
	wire [31:0] op = merge(operand_q, w_data_q, w_strb_q);
	wire [2:0] op_mode = op[OP_MODE_LSB +: 3];
	wire [3:0] op_long = op[OP_LONG_LSB +: 4];
	wire [8:0] op_val = op[OP_VAL_LSB +: 9];
	wire [5:0] op_pad = op[OP_PAD_LSB +: 6];
	// Mode 7 expands into the long-mode code space.
	wire [15:0] code = (op_mode == MODE_LONG) ? {op_long, 12'h007} : {13'h0000, op_mode};

	// Which resource kind is addressed, with the index in range.
	wire is_port = (sel_kind == KIND_PORT) && (sel_idx < 6'(NUM_PORTS));
	wire is_tmr = (sel_kind == KIND_TIMER) && (sel_idx < 6'(NUM_TIMERS));
	wire is_chan = (sel_kind == KIND_CHANEND) && (sel_idx < 6'(NUM_CHANENDS));
	wire is_cb = (sel_kind == KIND_CLKBLK) && (sel_idx < 6'(NUM_CLKBLKS));
	wire is_sdm = (sel_kind == KIND_SDM) && (sel_idx < 6'(NUM_SDM));
	wire v_le1 = op_val <= 9'h001;
	wire v_le2 = op_val <= 9'h002;
	wire one_bit = sel_idx < 6'(PORT_ONE_BIT_COUNT);
	wire cb_running = is_cb && cb_cfg_q[sel_idx[2:0]][CF_RUN];

	// Legality per kind; anything else leaves the resource state unchanged.
	wire port_ok = ((code == C_ENABLE) && v_le1) || ((code == C_COND) && v_le2) ||
		((code == C_NOTIFY) && v_le1) || ((code == C_DRIVE) && v_le2) ||
		(code == C_PAD) || ((code == C_RUN) && (op_val == port_buffer_flush)) ||
		((code == C_ROLE_MS) && v_le1) || ((code == C_BUFFERED) && v_le1) ||
		((code == C_READY) && v_le2) || ((code == C_SAMPLE) && v_le1) ||
		((code == C_PORT_USE) && (op_val == 9'h000 || (v_le2 && one_bit))) ||
		((code == C_INVERT) && v_le1) ||
		((code == C_IN_DELAY) && (op_val <= MAX_IN_DELAY));
	wire tmr_ok = ((code == C_COND) || (code == C_NOTIFY)) && v_le1;
	wire chan_ok = (code == C_NOTIFY) && v_le1;
	// A running clock block only accepts being stopped.
	wire cb_ok = cb_running ? ((code == C_RUN) && (op_val == 9'h000)) :
		(((code == C_ENABLE) || (code == C_RUN)) && v_le1) ||
		(code == C_FALL_DLY) || (code == C_RISE_DLY);
	wire sdm_ok = (((code == C_ENABLE) || (code == C_NOTIFY)) && v_le1) ||
		((code == C_RUN) && (op_val == run_start_command));
	wire accept = issue && ((is_port && port_ok) || (is_tmr && tmr_ok) ||
		(is_chan && chan_ok) || (is_cb && cb_ok) || (is_sdm && sdm_ok));
	wire resolve = accept && is_sdm && (code == C_RUN);

	// Next port word: the single addressed field is replaced.
	logic [PF_W-1:0] port_new;
	always_comb begin
		port_new = port_cfg_q[sel_idx];
		case (code)
			C_ENABLE: port_new[PF_EN] = op_val[0];
			C_COND: port_new[PF_COND +: 2] = op_val[1:0];
			C_NOTIFY: port_new[PF_IE] = op_val[0];
			C_DRIVE: port_new[PF_DRIVE +: 2] = op_val[1:0];
			C_PAD: port_new[PF_PAD +: 6] = op_pad;
			C_ROLE_MS: port_new[PF_MS] = op_val[0];
			C_BUFFERED: port_new[PF_BUF] = op_val[0];
			C_READY: port_new[PF_RDY +: 2] = op_val[1:0];
			C_SAMPLE: port_new[PF_SDEL] = op_val[0];
			C_PORT_USE: port_new[PF_ROLE +: 2] = op_val[1:0];
			C_INVERT: port_new[PF_INV] = op_val[0];
			C_IN_DELAY: port_new[PF_DLY +: 3] = op_val[2:0];
			default: port_new = port_cfg_q[sel_idx];
		endcase
	end

	// Next clock block word.
	logic [CF_W-1:0] cb_new;
	always_comb begin
		cb_new = cb_cfg_q[sel_idx[2:0]];
		case (code)
			C_ENABLE: cb_new[CF_EN] = op_val[0];
			C_RUN: cb_new[CF_RUN] = op_val[0];
			C_FALL_DLY: cb_new[CF_FALL +: 9] = op_val;
			C_RISE_DLY: cb_new[CF_RISE +: 9] = op_val;
			default: cb_new = cb_cfg_q[sel_idx[2:0]];
		endcase
	end

	// Read data selection; the view register shows the selected resource.
	logic [31:0] view;
	always_comb begin
		view = 32'h0000_0000;
		if (is_port) begin
			view = {9'h000, port_cfg_q[sel_idx]};
		end else if (is_tmr) begin
			view = {30'h0000_0000, tmr_irq_q[sel_idx[3:0]], tmr_after_q[sel_idx[3:0]]};
		end else if (is_chan) begin
			view = {31'h0000_0000, chan_irq_q[sel_idx[4:0]]};
		end else if (is_cb) begin
			view = {12'h000, cb_cfg_q[sel_idx[2:0]]};
		end else if (is_sdm) begin
			view = {29'h0000_0000, sdm_pend_q[sel_idx[0]], sdm_irq_q[sel_idx[0]],
				sdm_en_q[sel_idx[0]]};
		end
	end
	wire [31:0] test_view = is_port ? port_test_q[sel_idx] :
		(is_tmr ? tmr_cmp_q[sel_idx[3:0]] : 32'h0000_0000);
	wire [31:0] status = {22'h00_0000, sdm_pend_q, 5'h00, COND_PASS, refused_q, accepted_q};
	wire rd_known = (ARADDR == OFF_SELECT) || (ARADDR == OFF_CONFIG) ||
		(ARADDR == OFF_TEST) || (ARADDR == OFF_STATUS) || (ARADDR == OFF_VIEW);
	wire [31:0] rd_word = (ARADDR == OFF_SELECT) ? select_q :
		(ARADDR == OFF_CONFIG) ? operand_q :
		(ARADDR == OFF_TEST) ? test_view :
		(ARADDR == OFF_STATUS) ? status :
		(ARADDR == OFF_VIEW) ? view : 32'h0000_0000;

	// Condition result of the selected port against the sampled data.
	wire [1:0] sel_cond = port_cfg_q[sel_idx][PF_COND +: 2];
	wire cond_now = !is_port || (sel_cond == condition_absent) ||
		((sel_cond == condition_equal_test) && (PORT_SAMPLE == port_test_q[sel_idx])) ||
		((sel_cond == condition_not_equal_test) && (PORT_SAMPLE != port_test_q[sel_idx]));

	// Bus write side: holding flags and the write response.
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_full_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else begin
			if (AWVALID && !aw_full_q) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= AWADDR;
			end else if (wr_fire) begin
				aw_full_q <= 1'b0;
			end
			if (WVALID && !w_full_q) begin
				w_full_q <= 1'b1;
				w_data_q <= WDATA;
				w_strb_q <= WSTRB;
			end else if (wr_fire) begin
				w_full_q <= 1'b0;
			end
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_known ? RESP_OKAY : RESP_DECERR;
			end else if (BREADY) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Bus read side: one answer per address, held until taken.
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
		end else if (ARVALID && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= rd_known ? RESP_OKAY : RESP_DECERR;
		end else if (RREADY) begin
			rvalid_q <= 1'b0;
		end
	end

	// Select, operand and the outcome of the last instruction.
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			select_q <= 32'h0000_0000;
			operand_q <= 32'h0000_0000;
			accepted_q <= 1'b0;
			refused_q <= 1'b0;
		end else begin
			if (wr_fire && (aw_addr_q == OFF_SELECT)) begin
				select_q <= merge(select_q, w_data_q, w_strb_q);
			end
			if (issue) begin
				operand_q <= op;
				accepted_q <= accept;
				refused_q <= !accept;
			end
		end
	end

	// Port words and test operands.
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				port_cfg_q[i] <= PORT_RST;
				port_test_q[i] <= 32'h0000_0000;
			end
		end else begin
			if (accept && is_port) begin
				port_cfg_q[sel_idx] <= port_new;
			end
			if (test_wr && is_port) begin
				port_test_q[sel_idx] <= merge(port_test_q[sel_idx], w_data_q, w_strb_q);
			end
		end
	end

	// Buffer flush is a one-cycle pulse naming the port. Only the buffer is
	// touched, so the port word keeps its settings across a flush.
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			PORT_FLUSH <= 1'b0;
			PORT_FLUSH_IDX <= 6'h00;
		end else begin
			PORT_FLUSH <= accept && is_port && (code == C_RUN);
			if (accept && is_port && (code == C_RUN)) begin
				PORT_FLUSH_IDX <= sel_idx;
			end
		end
	end

	// Timers and channel ends.
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			tmr_after_q <= '0;
			tmr_irq_q <= '0;
			chan_irq_q <= '0;
			for (int i = 0; i < NUM_TIMERS; i++) begin
				tmr_cmp_q[i] <= 32'h0000_0000;
			end
		end else begin
			if (accept && is_tmr && (code == C_COND)) begin
				tmr_after_q[sel_idx[3:0]] <= op_val[0];
			end
			if (accept && is_tmr && (code == C_NOTIFY)) begin
				tmr_irq_q[sel_idx[3:0]] <= op_val[0];
			end
			if (accept && is_chan) begin
				chan_irq_q[sel_idx[4:0]] <= op_val[0];
			end
			if (test_wr && is_tmr) begin
				tmr_cmp_q[sel_idx[3:0]] <= merge(tmr_cmp_q[sel_idx[3:0]], w_data_q, w_strb_q);
			end
		end
	end

	// Timer ready and port condition are registered. The signed difference keeps
	// the comparison correct across a wrap of the free running count.
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			TIMER_READY <= '0;
			COND_PASS <= 1'b0;
		end else begin
			for (int i = 0; i < NUM_TIMERS; i++) begin
				TIMER_READY[i] <= !tmr_after_q[i] ||
					($signed(TIMER_NOW - tmr_cmp_q[i]) > 0);
			end
			COND_PASS <= cond_now;
		end
	end

	// Software memory: a miss while enabled sets pending, a resolve clears it; set wins.
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			sdm_en_q <= '0;
			sdm_irq_q <= '0;
			sdm_pend_q <= '0;
		end else begin
			if (accept && is_sdm && (code == C_ENABLE)) begin
				sdm_en_q[sel_idx[0]] <= op_val[0];
			end
			if (accept && is_sdm && (code == C_NOTIFY)) begin
				sdm_irq_q[sel_idx[0]] <= op_val[0];
			end
			for (int i = 0; i < NUM_SDM; i++) begin
				if (sdm_en_q[i] && SDM_MISS[i]) begin
					sdm_pend_q[i] <= 1'b1;
				end else if (resolve && (sel_idx[0] == 1'(i))) begin
					sdm_pend_q[i] <= 1'b0;
				end
			end
		end
	end
	assign SDM_ROUTE = sdm_en_q;
	assign SDM_EVENT = sdm_pend_q & ~sdm_irq_q;
	assign SDM_IRQ = sdm_pend_q & sdm_irq_q;

	// Clock block words.
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			for (int i = 0; i < NUM_CLKBLKS; i++) begin
				cb_cfg_q[i] <= CLKBLK_RST;
			end
		end else if (accept && is_cb) begin
			cb_cfg_q[sel_idx[2:0]] <= cb_new;
		end
	end

	// Clock block edge engines. Each input edge loads its delay; an edge still
	// pending when the opposite input edge comes is forced out at once, or dropped
	// if the new delay is zero, so no delay ever runs past the next input edge.
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			src_q <= '0;
			pend_q <= '0;
			pend_lvl_q <= '0;
			CB_OUT <= '0;
			CB_RUNNING <= '0;
			for (int i = 0; i < NUM_CLKBLKS; i++) begin
				cnt_q[i] <= 9'h000;
			end
		end else begin
			src_q <= CB_SRC;
			for (int i = 0; i < NUM_CLKBLKS; i++) begin
				CB_RUNNING[i] <= cb_cfg_q[i][CF_EN] && cb_cfg_q[i][CF_RUN];
				if (!(cb_cfg_q[i][CF_EN] && cb_cfg_q[i][CF_RUN])) begin
					CB_OUT[i] <= 1'b0;
					pend_q[i] <= 1'b0;
				end else if (CB_SRC[i] != src_q[i]) begin
					// Delay for the new level: rise or fall field.
					cnt_q[i] <= CB_SRC[i] ? cb_cfg_q[i][CF_RISE +: 9] : cb_cfg_q[i][CF_FALL +: 9];
					pend_lvl_q[i] <= CB_SRC[i];
					if ((CB_SRC[i] ? cb_cfg_q[i][CF_RISE +: 9] : cb_cfg_q[i][CF_FALL +: 9])
							== 9'h000) begin
						CB_OUT[i] <= CB_SRC[i];
						pend_q[i] <= 1'b0;
					end else begin
						CB_OUT[i] <= pend_q[i] ? pend_lvl_q[i] : CB_OUT[i];
						pend_q[i] <= 1'b1;
					end
				end else if (pend_q[i]) begin
					if (cnt_q[i] == 9'h001) begin
						CB_OUT[i] <= pend_lvl_q[i];
						pend_q[i] <= 1'b0;
					end
					cnt_q[i] <= cnt_q[i] - 9'h001;
				end
			end
		end
	end
endmodule

// >>> design/rcd_pkg.sv
// Constants, encodings and field layouts for the resource configuration decoder.
package rcd_pkg;
	// Resource counts; ports below PORT_ONE_BIT_COUNT are single-bit ports.
	localparam int NUM_PORTS = 49;
	localparam int PORT_ONE_BIT_COUNT = 32;
	localparam int NUM_TIMERS = 10;
	localparam int NUM_CHANENDS = 32;
	localparam int NUM_CLKBLKS = 6;
	localparam int NUM_SDM = 2;
	// Resource kinds as written into the select register.
	typedef enum logic [2:0] {KIND_PORT, KIND_TIMER, KIND_CHANEND, KIND_CLKBLK, KIND_SDM} res_kind_t;
	// Bus register byte offsets.
	localparam logic [7:0] OFF_SELECT = 8'h00;
	localparam logic [7:0] OFF_CONFIG = 8'h04;
	localparam logic [7:0] OFF_TEST = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam logic [7:0] OFF_VIEW = 8'h10;
	// Select register fields.
	localparam int SEL_KIND_LSB = 0;
	localparam int SEL_IDX_LSB = 8;
	// Operand fields of the configuration instruction.
	localparam int OP_MODE_LSB = 0;
	localparam int OP_VAL_LSB = 3;
	localparam int OP_LONG_LSB = 12;
	localparam int OP_PAD_LSB = 18;
	localparam logic [2:0] MODE_LONG = 3'h7;
	// Effective mode codes after long-mode expansion.
	localparam logic [15:0] C_ENABLE = 16'h0000;
	localparam logic [15:0] C_COND = 16'h0001;
	localparam logic [15:0] C_NOTIFY = 16'h0002;
	localparam logic [15:0] C_DRIVE = 16'h0003;
	localparam logic [15:0] C_PAD = 16'h0006;
	localparam logic [15:0] C_RUN = 16'h0007;
	localparam logic [15:0] C_ROLE_MS = 16'h1007;
	localparam logic [15:0] C_BUFFERED = 16'h2007;
	localparam logic [15:0] C_READY = 16'h3007;
	localparam logic [15:0] C_SAMPLE = 16'h4007;
	localparam logic [15:0] C_PORT_USE = 16'h5007;
	localparam logic [15:0] C_INVERT = 16'h6007;
	localparam logic [15:0] C_IN_DELAY = 16'h7007;
	localparam logic [15:0] C_FALL_DLY = 16'h8007;
	localparam logic [15:0] C_RISE_DLY = 16'h9007;
	// Value encodings.
	localparam logic [1:0] condition_absent = 2'h0;
	localparam logic [1:0] condition_equal_test = 2'h1;
	localparam logic [1:0] condition_not_equal_test = 2'h2;
	localparam logic [8:0] port_buffer_flush = 9'h002;
	localparam logic [8:0] run_start_command = 9'h001;
	localparam logic [8:0] MAX_IN_DELAY = 9'h004;
	// Port configuration word layout.
	localparam int PF_EN = 0;
	localparam int PF_COND = 1;
	localparam int PF_IE = 3;
	localparam int PF_DRIVE = 4;
	localparam int PF_PAD = 6;
	localparam int PF_MS = 12;
	localparam int PF_BUF = 13;
	localparam int PF_RDY = 14;
	localparam int PF_SDEL = 16;
	localparam int PF_ROLE = 17;
	localparam int PF_INV = 19;
	localparam int PF_DLY = 20;
	localparam int PF_W = 23;
	// Reset value of a port word: off, no condition, events, data port, unbuffered.
	localparam logic [22:0] PORT_RST = 23'h00_0000;
	// Clock block word: enable, running, fall delay, rise delay.
	localparam int CF_EN = 0;
	localparam int CF_RUN = 1;
	localparam int CF_FALL = 2;
	localparam int CF_RISE = 11;
	localparam int CF_W = 20;
	localparam logic [19:0] CLKBLK_RST = 20'h0_0000;
	// Bus responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// >>> verification/rcd_monitor.sv
// Concurrent checks on the decoder's bus handshakes and resource outputs.
`timescale 1ns/1ps
module rcd_monitor (
	input wire logic REF_CLK,
	input wire logic ARST_N,
	input wire logic AWVALID,
	input wire logic AWREADY,
	input wire logic WVALID,
	input wire logic WREADY,
	input wire logic BVALID,
	input wire logic BREADY,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic RVALID,
	input wire logic RREADY,
	input wire logic PORT_FLUSH,
	input wire logic [rcd_pkg::NUM_CLKBLKS-1:0] CB_OUT,
	input wire logic [rcd_pkg::NUM_CLKBLKS-1:0] CB_RUNNING,
	input wire logic [rcd_pkg::NUM_SDM-1:0] SDM_MISS,
	input wire logic [rcd_pkg::NUM_SDM-1:0] SDM_ROUTE,
	input wire logic [rcd_pkg::NUM_SDM-1:0] SDM_EVENT,
	input wire logic [rcd_pkg::NUM_SDM-1:0] SDM_IRQ
);
	// One clock domain, so clock and reset are given once for every check.
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!ARST_N);
	// The write answer lands two edges after both halves are taken together.
	write_answer_a: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
		else $error("late write answer");
	read_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
		else $error("late read answer");
	// An answer is withdrawn only after the master has accepted it.
	b_release_a: assert property ($fell(BVALID) |-> $past(BREADY))
		else $error("write answer dropped");
	r_release_a: assert property ($fell(RVALID) |-> $past(RREADY))
		else $error("read answer dropped");
	flush_pulse_a: assert property (PORT_FLUSH |=> !PORT_FLUSH)
		else $error("long flush pulse");
	cb_quiet_a: assert property (!CB_RUNNING[0] [*2] |-> !CB_OUT[0])
		else $error("idle clock output high");
	notify_excl_a: assert property ((SDM_EVENT & SDM_IRQ) == '0)
		else $error("event and interrupt together");
	miss_raise_a: assert property (SDM_ROUTE[0] && SDM_MISS[0]
		|=> SDM_EVENT[0] || SDM_IRQ[0]) else $error("miss not signalled");
endmodule
bind resource_config_decoder rcd_monitor rcd_monitor_inst (.REF_CLK, .ARST_N, .AWVALID, .AWREADY,
	.WVALID, .WREADY, .BVALID, .BREADY, .ARVALID, .ARREADY, .RVALID, .RREADY, .PORT_FLUSH,
	.CB_OUT, .CB_RUNNING, .SDM_MISS, .SDM_ROUTE, .SDM_EVENT, .SDM_IRQ);

// >>> verification/cpu.sv
// Processor thread model that issues configuration words over the register bus.
`timescale 1ns/1ps
module cpu (
	input wire logic REF_CLK,
	output logic [7:0] AWADDR,
	output logic AWVALID,
	input wire logic AWREADY,
	output logic [31:0] WDATA,
	output logic [3:0] WSTRB,
	output logic WVALID,
	input wire logic WREADY,
	input wire logic [1:0] BRESP,
	input wire logic BVALID,
	output logic BREADY,
	output logic [7:0] ARADDR,
	output logic ARVALID,
	input wire logic ARREADY,
	input wire logic [31:0] RDATA,
	input wire logic [1:0] RRESP,
	input wire logic RVALID,
	output logic RREADY
);
	// Answers are always welcome, so both ready lines stay high for the whole run.
	initial begin
		{AWADDR, AWVALID, WDATA, WVALID, ARADDR, ARVALID} = '0;
		{BREADY, RREADY, WSTRB} = 6'h3f;
	end
	// Handshakes are judged at the falling edge, so releases land just after the taking edge.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ah, wh;
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		do begin
			@(negedge REF_CLK);
			ah = AWVALID & AWREADY;
			wh = WVALID & WREADY;
			@(posedge REF_CLK);
			if (ah) AWVALID <= 1'b0;
			if (wh) WVALID <= 1'b0;
		end while (AWVALID & ~ah | WVALID & ~wh);
		do begin
			@(negedge REF_CLK);
			ah = BVALID;
			r = BRESP;
			@(posedge REF_CLK);
		end while (!ah);
	endtask
	// One read; the address is released at the edge that takes it.
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic h;
		ARADDR <= a;
		ARVALID <= 1'b1;
		do begin
			@(negedge REF_CLK);
			h = ARREADY;
			@(posedge REF_CLK);
		end while (!h);
		ARVALID <= 1'b0;
		do begin
			@(negedge REF_CLK);
			h = RVALID;
			d = RDATA;
			r = RRESP;
			@(posedge REF_CLK);
		end while (!h);
	endtask
endmodule

// >>> verification/tb_top.sv
// Self-checking bench: the thread model drives the decoder, a reference model predicts it.
`timescale 1ns/1ps
module tb_top;
	import rcd_pkg::*;
	logic REF_CLK = 1'b0;
	logic ARST_N = 1'b0;
	logic [7:0] AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA, rv, ev, t;
	logic [3:0] WSTRB;
	logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
	logic [1:0] BRESP, RRESP, rsp;
	logic [31:0] TIMER_NOW = '0, PORT_SAMPLE = '0;
	logic [NUM_CLKBLKS-1:0] CB_SRC = '0, CB_OUT, CB_RUNNING;
	logic [NUM_SDM-1:0] SDM_MISS = '0, SDM_ROUTE, SDM_EVENT, SDM_IRQ;
	logic PORT_FLUSH, COND_PASS;
	logic [5:0] PORT_FLUSH_IDX, fl_idx;
	logic [NUM_TIMERS-1:0] TIMER_READY;
	int n_mismatch = 0, checks_done = 0, cyc = 0, flushes = 0, idx, d;
	// Port settings: code, field position, width and largest legal value.
	logic [15:0] pc [11] = '{C_ENABLE, C_COND, C_NOTIFY, C_DRIVE, C_ROLE_MS, C_BUFFERED,
		C_READY, C_SAMPLE, C_PORT_USE, C_INVERT, C_IN_DELAY};
	int pl [11] = '{PF_EN, PF_COND, PF_IE, PF_DRIVE, PF_MS, PF_BUF, PF_RDY, PF_SDEL, PF_ROLE,
		PF_INV, PF_DLY};
	int pw [11] = '{1, 2, 1, 2, 1, 1, 2, 1, 2, 1, 3};
	int pm [11] = '{1, 2, 1, 2, 1, 1, 2, 1, 2, 1, 4};
	// Time offsets around the comparison point, including the signed wrap.
	logic [31:0] toff [4] = '{32'hffff_ffff, 32'h0000_0000, 32'h0000_0001, 32'h8000_0000};
	resource_config_decoder resource_config_decoder_inst (.REF_CLK, .ARST_N, .AWADDR, .AWVALID,
		.AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID,
		.ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .TIMER_NOW, .PORT_SAMPLE, .CB_SRC, .SDM_MISS,
		.PORT_FLUSH, .PORT_FLUSH_IDX, .COND_PASS, .TIMER_READY, .CB_OUT, .CB_RUNNING, .SDM_ROUTE,
		.SDM_EVENT, .SDM_IRQ);
	cpu cpu_inst (.REF_CLK, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY,
		.BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY);
	always #20 REF_CLK = ~REF_CLK;
	// Flush pulses are counted off the edge, so a one-cycle pulse is never missed.
	always @(negedge REF_CLK) if (PORT_FLUSH === 1'b1) begin
		flushes++;
		fl_idx = PORT_FLUSH_IDX;
	end
	// A hung handshake is cut short well past the fewer than one thousand cycles the run needs.
	always @(posedge REF_CLK) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			close_out();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			n_mismatch++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask
	task automatic close_out();
		if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic sel(input res_kind_t k, input int i);
		cpu_inst.wr(OFF_SELECT, {18'h0, i[5:0], 5'h0, k}, rsp);
	endtask
	// Issues one operand, checks the accept or refuse flags and fetches the view.
	task automatic cfg(input logic [15:0] c, input logic [8:0] v, input bit ok);
		cpu_inst.wr(OFF_CONFIG, {16'h0, c[15:12], v, c[2:0]}, rsp);
		cpu_inst.rd(OFF_STATUS, rv, rsp);
		chk(rv[1:0], ok ? 2'b01 : 2'b10);
		cpu_inst.rd(OFF_VIEW, rv, rsp);
	endtask
	// A refused setting must leave the expected view untouched.
	task automatic pset(input int i, input int v, input bit ok);
		cfg(pc[i], v[8:0], ok);
		if (ok) ev = ev & ~(((32'h1 << pw[i]) - 1) << pl[i]) | v << pl[i];
		chk(rv, ev);
	endtask
	task automatic settle();
		repeat (8) @(posedge REF_CLK);
		@(negedge REF_CLK);
	endtask
	initial begin
		void'($urandom(32'h4bd9));
		repeat (8) @(posedge REF_CLK);
		ARST_N <= 1'b1;
		@(posedge REF_CLK);
		idx = $urandom_range(PORT_ONE_BIT_COUNT - 1);
		sel(KIND_PORT, idx);
		cpu_inst.rd(OFF_VIEW, rv, rsp);
		ev = {9'h000, PORT_RST};
		chk(rv, ev);
		for (int r = 0; r < 2; r++) begin
			for (int i = 0; i < 11; i++) begin
				pset(i, $urandom_range(pm[i]), 1);
				if (pw[i] > 1) pset(i, pm[i] + 1, 0);
			end
		end
		t = $urandom;
		cpu_inst.wr(OFF_CONFIG, {t[31:24], t[5:0], 15'h0000, C_PAD[2:0]}, rsp);
		cpu_inst.rd(OFF_VIEW, rv, rsp);
		ev[PF_PAD +: 6] = t[5:0];
		chk(rv, ev);
		cfg(C_RUN, port_buffer_flush, 1);
		chk(flushes, 1);
		chk(fl_idx, idx);
		pset(0, 1, 1);
		pset(9, 0, 1);
		pset(1, 1, 1);
		cpu_inst.wr(OFF_TEST, t, rsp);
		PORT_SAMPLE <= t;
		chk(rsp, RESP_OKAY);
		settle();
		chk(COND_PASS, 1);
		@(posedge REF_CLK);
		pset(1, 2, 1);
		settle();
		chk(COND_PASS, 0);
		@(posedge REF_CLK);
		sel(KIND_PORT, 40);
		cfg(C_PORT_USE, 1, 0);
		sel(KIND_TIMER, NUM_TIMERS - 1);
		cfg(C_COND, 1, 1);
		cfg(C_DRIVE, 1, 0);
		cfg(C_NOTIFY, 1, 1);
		chk(rv, 3);
		cpu_inst.wr(OFF_TEST, t, rsp);
		for (int k = 0; k < 4; k++) begin
			TIMER_NOW <= t + toff[k];
			settle();
			chk(TIMER_READY[NUM_TIMERS - 1], $signed(toff[k]) > 0);
			@(posedge REF_CLK);
		end
		sel(KIND_CLKBLK, 0);
		cfg(C_ENABLE, 1, 1);
		cfg(C_FALL_DLY, 2, 1);
		cfg(C_RISE_DLY, 3, 1);
		cfg(C_RUN, run_start_command, 1);
		cfg(C_FALL_DLY, 5, 0);
		chk(rv, 3 | 2 << CF_FALL | 3 << CF_RISE);
		chk(CB_RUNNING[0], 1);
		// The programmed delay must pass before the output follows the input.
		for (int k = 0; k < 4; k++) begin
			d = CB_SRC[0] ? 2 : 3;
			CB_SRC[0] <= ~CB_SRC[0];
			repeat (d) @(posedge REF_CLK);
			@(negedge REF_CLK);
			chk(CB_OUT[0], !CB_SRC[0]);
			settle();
			chk(CB_OUT[0], CB_SRC[0]);
			@(posedge REF_CLK);
		end
		cfg(C_RUN, 0, 1);
		chk(CB_RUNNING[0], 0);
		sel(KIND_SDM, 0);
		cfg(C_ENABLE, 1, 1);
		cfg(C_NOTIFY, 1, 1);
		SDM_MISS[0] <= 1'b1;
		@(posedge REF_CLK);
		SDM_MISS[0] <= 1'b0;
		settle();
		chk({SDM_ROUTE[0], SDM_IRQ[0], SDM_EVENT[0]}, 3'b110);
		@(posedge REF_CLK);
		cfg(C_RUN, 1, 1);
		chk({rv[2:0], SDM_IRQ[0]}, 4'h6);
		sel(KIND_CHANEND, NUM_CHANENDS - 1);
		cfg(C_COND, 1, 0);
		cfg(C_NOTIFY, 1, 1);
		chk(rv, 1);
		cpu_inst.wr(8'h14, t, rsp);
		chk(rsp, RESP_DECERR);
		cpu_inst.rd(8'h14, rv, rsp);
		chk(rsp, RESP_DECERR);
		chk(rv, 32'h0000_0000);
		close_out();
	end
endmodule
